// File: printer_parallel_port_glue.sv
/*
  Printer port glue around a two-channel parallel I/O unit: channel A
  sends bytes to a parallel printer, channel B reads printer status.
  Assumes the processor bus and printer pins are asynchronous to
  core_clk; each is passed through two flip-flops before use.
*/
// Function
// - channel A is an output-only byte channel driving printer data
// - printer acknowledge feeds channel A strobe; A ready makes strobe
// - printer data strobe lasts 1 us, shaped by a shift register
// - channel A ready is delayed and stretched before reaching printer
// - channel B status: fault_n, busy, no paper, selected in bits 0-3
// - status bits 4 to 6 always read zero
// - status bit 7 shows serial port B DSR line, inverted
// - printer init follows board reset, no software control
// - peripheral fetch input low when fetch or board reset low
// - long low on fetch input resets the parallel unit
// - fetch active with read and I/O request idle means reset
// - fetch and I/O request both low is interrupt acknowledge
// - accesses happen only while chip select is low
// - address bit A0 selects channel A or B
// - address bit A1 selects control or data word
// - words move on the bus only with I/O request low, and select low too except in interrupt acknowledge
// - read input sets transfer direction
// - interrupt request output is open-drain, wire-or capable
`default_nettype none

module printer_parallel_port_glue #(
  parameter int FETCH_RESET_LEN = printer_port_pkg::FETCH_RESET_CYCLES,
  parameter int TICK_LEN        = printer_port_pkg::TICK_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       fetch_cycle_n,
  input  wire logic       io_request_n,
  input  wire logic       read_n,
  input  wire logic       chip_select_n,
  input  wire logic       addr_a0,
  input  wire logic       addr_a1,
  input  wire logic [7:0] cpu_data_in,
  output logic [7:0]      cpu_data_out,
  output logic            cpu_data_oe,
  output logic            bus_wait_n,
  input  wire logic       board_reset_n,
  output logic            periph_fetch_n,
  output logic            printer_init_n,
  output logic [7:0]      printer_data,
  output logic            printer_strobe_n,
  input  wire logic       first_channel_ack_in_n,
  input  wire logic       printer_fault_n,
  input  wire logic       printer_busy,
  input  wire logic       printer_no_paper,
  input  wire logic       printer_selected,
  input  wire logic       serial_b_dsr_line,
  output logic            irq_n_out,
  output logic            irq_n_oe
);
  import printer_port_pkg::*;

  localparam int FW = $clog2(FETCH_RESET_LEN + 1);
  localparam int TW = $clog2(TICK_LEN + 1);

  if (FETCH_RESET_LEN < 2 || TICK_LEN < 1 || STROBE_TICKS < 1)
  begin : g_bad
    $error("printer port: counts too small");
  end

  // ==========================================================
  // input synchronisers
  bus_pins_s  bus_m_q;
  bus_pins_s  bus_s_q;
  line_pins_s ln_m_q;
  line_pins_s ln_s_q;

  always_ff @(posedge core_clk) begin
    bus_m_q <= {fetch_cycle_n, io_request_n, read_n, chip_select_n,
                addr_a1, addr_a0, cpu_data_in};
    bus_s_q <= bus_m_q;
    ln_m_q  <= {board_reset_n, first_channel_ack_in_n,
                serial_b_dsr_line, printer_selected, printer_no_paper,
                printer_busy, printer_fault_n};
    ln_s_q  <= ln_m_q;
  end

  // ==========================================================
  // combined fetch / reset line
  logic          fetch_comb_n;
  logic          reset_cond;
  logic [FW-1:0] fetch_cnt_q;
  logic          fetch_rst_q;
  logic          unit_rst;

  assign fetch_comb_n = bus_s_q.fetch_n & ln_s_q.board_reset_n;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      periph_fetch_n <= 1'b0;
      printer_init_n <= 1'b0;
    end else begin
      periph_fetch_n <= fetch_comb_n;
      printer_init_n <= ln_s_q.board_reset_n;
    end
  end

  // a normal fetch always carries read or I/O request, so only a
  // bare low that outlasts the limit is taken as reset
  assign reset_cond = ~fetch_comb_n & bus_s_q.rd_n & bus_s_q.ioreq_n;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fetch_cnt_q <= '0;
      fetch_rst_q <= 1'b0;
    end else if (reset_cond) begin
      if (fetch_cnt_q != FW'(FETCH_RESET_LEN - 1)) begin
        fetch_cnt_q <= fetch_cnt_q + 1'b1;
      end else begin
        fetch_rst_q <= 1'b1;
      end
    end else begin
      fetch_cnt_q <= '0;
      fetch_rst_q <= 1'b0;
    end
  end

  assign unit_rst = rst | fetch_rst_q;

  // ==========================================================
  // bus decode
  logic io_sel;
  logic int_ack;
  logic acc_q;
  logic ack_cyc_q;
  logic acc_start;
  logic wr_start;
  logic ch_b;
  logic is_ctrl;

  assign io_sel    = ~bus_s_q.ioreq_n & ~bus_s_q.cs_n
                   & fetch_comb_n;
  assign int_ack   = ~fetch_comb_n & ~bus_s_q.ioreq_n;
  assign acc_start = io_sel & ~acc_q;
  assign wr_start  = acc_start & bus_s_q.rd_n;
  assign ch_b      = bus_s_q.a0;
  assign is_ctrl   = bus_s_q.a1;

  always_ff @(posedge core_clk) begin
    if (unit_rst) begin
      acc_q     <= 1'b0;
      ack_cyc_q <= 1'b0;
    end else begin
      acc_q     <= io_sel;
      ack_cyc_q <= int_ack;
    end
  end

  // ==========================================================
  // status byte
  logic [7:0] status_byte;

  always_comb begin
    status_byte              = BYTE_ZERO;
    status_byte[ST_FAULT]    = ln_s_q.fault_n;
    status_byte[ST_BUSY]     = ln_s_q.busy;
    status_byte[ST_NO_PAPER] = ln_s_q.no_paper;
    status_byte[ST_SELECTED] = ln_s_q.selected;
    status_byte[ST_DSR]      = ~ln_s_q.dsr_line;
  end

  // ==========================================================
  // per-channel control words and interrupt flags
  cw_state_e   cw_q     [NUM_CH];
  logic [1:0]  mode_q   [NUM_CH];
  logic        irq_en_q [NUM_CH];
  logic [7:0]  mask_q   [NUM_CH];
  logic [7:0]  dir_q    [NUM_CH];
  logic [7:0]  vector_q [NUM_CH];
  logic [NUM_CH-1:0] pend_q;
  logic [NUM_CH-1:0] evt;
  logic        ack_take;
  logic        srv_q;
  logic        ack_own_q;
  pr_state_e   pr_q;
  logic        b_hit;
  logic        b_hit_q;
  logic [7:0]  d;

  assign d        = bus_s_q.data;
  assign b_hit    = |(status_byte & ~mask_q[CH_B] & dir_q[CH_B]);
  assign ack_take = int_ack & ~ack_cyc_q & (|pend_q);
  assign evt[CH_A] = (pr_q == PR_REL) & ln_s_q.ack_n & irq_en_q[CH_A];
  assign evt[CH_B] = b_hit & ~b_hit_q & irq_en_q[CH_B]
                   & (mode_q[CH_B] == MODE_BIT);

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic wr_ctl;
    logic srv_me;

    assign wr_ctl = wr_start & is_ctrl & (ch_b == 1'(c));
    assign srv_me = ack_take & (pend_q[CH_A] ? (c == CH_A) : (c == CH_B));

    always_ff @(posedge core_clk) begin
      if (unit_rst) begin
        cw_q[c]     <= CW_ANY;
        mode_q[c]   <= MODE_IN;
        irq_en_q[c] <= 1'b0;
        mask_q[c]   <= MASK_RESET;
        dir_q[c]    <= DIR_RESET;
        vector_q[c] <= BYTE_ZERO;
      end else if (wr_ctl) begin
        case (cw_q[c])
          CW_DIR: begin
            dir_q[c] <= d;
            cw_q[c]  <= CW_ANY;
          end
          CW_MASK: begin
            mask_q[c] <= d;
            cw_q[c]   <= CW_ANY;
          end
          CW_ANY: begin
            if (!d[CW_VEC_BIT]) begin
              vector_q[c] <= d;
            end else if (d[3:0] == CW_MODE_TAG) begin
              mode_q[c] <= d[CW_MODE_LSB +: 2];
              if (d[CW_MODE_LSB +: 2] == MODE_BIT) begin
                cw_q[c] <= CW_DIR;
              end
            end else if (d[3:0] == CW_INT_TAG) begin
              irq_en_q[c] <= d[CW_IEN_BIT];
              if (d[CW_MASK_NEXT_BIT]) begin
                cw_q[c] <= CW_MASK;
              end
            end else if (d[3:0] == CW_IEN_TAG) begin
              irq_en_q[c] <= d[CW_IEN_BIT];
            end
          end
          default: begin
            cw_q[c] <= CW_ANY;
          end
        endcase
      end
    end

    // a new event in the acknowledge cycle stays pending
    always_ff @(posedge core_clk) begin
      if (unit_rst) begin
        pend_q[c] <= 1'b0;
      end else begin
        pend_q[c] <= evt[c] | (pend_q[c] & ~srv_me);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (unit_rst) begin
      b_hit_q   <= 1'b0;
      srv_q     <= 1'b0;
      ack_own_q <= 1'b0;
    end else begin
      b_hit_q <= b_hit;
      if (ack_take) begin
        srv_q     <= ~pend_q[CH_A];
        ack_own_q <= 1'b1;
      end else if (!int_ack) begin
        ack_own_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (unit_rst) begin
      irq_n_out <= 1'b0;
      irq_n_oe  <= 1'b0;
    end else begin
      irq_n_out <= 1'b0;
      irq_n_oe  <= |pend_q;
    end
  end

  // ==========================================================
  // channel A data and word buffer
  logic       wr_a_data;
  logic [7:0] a_data_q;
  logic       push_q;
  logic       buf_in_ready;
  logic [7:0] buf_data;
  logic       buf_valid;
  logic       buf_take;

  assign wr_a_data = wr_start & ~is_ctrl & ~ch_b
                   & (mode_q[CH_A] == MODE_OUT);

  always_ff @(posedge core_clk) begin
    if (unit_rst) begin
      a_data_q   <= BYTE_ZERO;
      push_q     <= 1'b0;
      bus_wait_n <= 1'b1;
    end else begin
      if (wr_a_data) begin
        a_data_q <= d;
      end
      push_q     <= wr_a_data | (push_q & ~buf_in_ready);
      // stalls the processor while a word waits for buffer room
      bus_wait_n <= ~(push_q & ~buf_in_ready);
    end
  end

  port_buffer #(
    .WIDTH (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .core_clk  (core_clk),
    .rst       (unit_rst),
    .in_data   (a_data_q),
    .in_valid  (push_q),
    .in_ready  (buf_in_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_take)
  );

  // ==========================================================
  // printer handshake and strobe stretcher
  logic [TW-1:0]         tick_cnt_q;
  logic                  tick;
  logic [STROBE_TICKS:0] sr_q;
  logic                  ready_q;
  logic                  strobe_on;

  assign tick      = (tick_cnt_q == TW'(TICK_LEN - 1));
  assign buf_take  = (pr_q == PR_IDLE);
  assign strobe_on = sr_q[0] & ~sr_q[STROBE_TICKS];

  always_ff @(posedge core_clk) begin
    if (unit_rst) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (unit_rst) begin
      pr_q         <= PR_IDLE;
      ready_q      <= 1'b0;
      sr_q         <= '0;
      printer_data <= BYTE_ZERO;
    end else begin
      case (pr_q)
        PR_IDLE: begin
          if (buf_valid) begin
            printer_data <= buf_data;
            ready_q      <= 1'b1;
            sr_q         <= '0;
            pr_q         <= PR_STROBE;
          end
        end
        PR_STROBE: begin
          if (tick) begin
            sr_q <= {sr_q[STROBE_TICKS-1:0], ready_q};
          end
          if (sr_q[STROBE_TICKS]) begin
            pr_q <= PR_ACK;
          end
        end
        PR_ACK: begin
          if (!ln_s_q.ack_n) begin
            ready_q <= 1'b0;
            pr_q    <= PR_REL;
          end
        end
        PR_REL: begin
          if (ln_s_q.ack_n) begin
            pr_q <= PR_IDLE;
          end
        end
        default: begin
          pr_q <= PR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (unit_rst) begin
      printer_strobe_n <= 1'b1;
    end else begin
      printer_strobe_n <= ~strobe_on;
    end
  end

  // ==========================================================
  // processor read data
  always_ff @(posedge core_clk) begin
    if (unit_rst) begin
      cpu_data_oe  <= 1'b0;
      cpu_data_out <= BYTE_ZERO;
    end else if (int_ack && (ack_own_q || ack_take)) begin
      cpu_data_oe  <= 1'b1;
      cpu_data_out <= ack_own_q ? vector_q[srv_q]
                    : vector_q[~pend_q[CH_A]];
    end else if (io_sel && !bus_s_q.rd_n) begin
      cpu_data_oe <= 1'b1;
      if (is_ctrl) begin
        cpu_data_out <= READ_CTRL;
      end else if (ch_b) begin
        cpu_data_out <= status_byte;
      end else begin
        cpu_data_out <= a_data_q;
      end
    end else begin
      cpu_data_oe  <= 1'b0;
      cpu_data_out <= BYTE_ZERO;
    end
  end

endmodule

`default_nettype wire

// File: port_buffer.sv
/*
  Shared constants, carrier types and the small word buffer of the
  printer port. Assumes one clock, core_clk at 200 MHz, and a
  synchronous active-high reset.
*/
`default_nettype none

package printer_port_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int SYS_TICK_NS    = 250;   // 4 MHz system clock period
  localparam int STROBE_NS      = 1000;
  localparam int FETCH_RESET_NS = 2000;
  localparam int TICK_CYCLES    =
    (SYS_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_TICKS   = STROBE_NS / SYS_TICK_NS;
  localparam int FETCH_RESET_CYCLES =
    (FETCH_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // sizes
  localparam int DATA_W    = 8;
  localparam int BUF_DEPTH = 2;
  localparam int NUM_CH    = 2;
  localparam int CH_A      = 0;
  localparam int CH_B      = 1;

  // ==========================================================
  // control words
  localparam logic [1:0] MODE_OUT   = 2'h0;
  localparam logic [1:0] MODE_IN    = 2'h1;
  localparam logic [1:0] MODE_BIT   = 2'h3;
  localparam logic [3:0] CW_MODE_TAG = 4'hF;
  localparam logic [3:0] CW_INT_TAG  = 4'h7;
  localparam logic [3:0] CW_IEN_TAG  = 4'h3;
  localparam int CW_MODE_LSB      = 6;
  localparam int CW_IEN_BIT       = 7;
  localparam int CW_MASK_NEXT_BIT = 4;
  localparam int CW_VEC_BIT       = 0;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] DIR_RESET  = 8'hFF;
  localparam logic [7:0] READ_CTRL  = 8'h00;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;

  // ==========================================================
  // status byte layout
  localparam int ST_FAULT    = 0;
  localparam int ST_BUSY     = 1;
  localparam int ST_NO_PAPER = 2;
  localparam int ST_SELECTED = 3;
  localparam int ST_DSR      = 7;

  // ==========================================================
  // carriers and states
  typedef struct packed {
    logic       fetch_n;
    logic       ioreq_n;
    logic       rd_n;
    logic       cs_n;
    logic       a1;
    logic       a0;
    logic [7:0] data;
  } bus_pins_s;

  typedef struct packed {
    logic board_reset_n;
    logic ack_n;
    logic dsr_line;
    logic selected;
    logic no_paper;
    logic busy;
    logic fault_n;
  } line_pins_s;

  typedef enum logic [1:0] {CW_ANY, CW_DIR, CW_MASK} cw_state_e;
  typedef enum logic [1:0] {PR_IDLE, PR_STROBE, PR_ACK, PR_REL}
    pr_state_e;

endpackage

module port_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("port_buffer: DEPTH must be 2 or more");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

`default_nettype wire

// File: printer_glue_chk.sv
/*
  Checker for the printer port glue, watching its ports only.
  Assumes one clock and a synchronous reset; bound below.
*/
`default_nettype none
module printer_glue_chk #(
  parameter int FETCH_RESET_LEN = 8,
  parameter int TICK_LEN        = 2
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       fetch_cycle_n,
  input wire logic       io_request_n,
  input wire logic       read_n,
  input wire logic       addr_a0,
  input wire logic       addr_a1,
  input wire logic [7:0] cpu_data_out,
  input wire logic       cpu_data_oe,
  input wire logic       board_reset_n,
  input wire logic       periph_fetch_n,
  input wire logic       printer_init_n,
  input wire logic [7:0] printer_data,
  input wire logic       printer_strobe_n,
  input wire logic       irq_n_out,
  input wire logic       irq_n_oe
);
  int         lo_q;
  int         fr_q;
  logic [2:0] up_q;
  // ==========
  // helper counters
  always_ff @(posedge core_clk)
    lo_q <= (rst || printer_strobe_n) ? 0 : lo_q + 1;
  always_ff @(posedge core_clk)
    fr_q <= (rst || !read_n || !io_request_n ||
      (fetch_cycle_n && board_reset_n)) ? 0 : fr_q + 1;
  // synchronisers hold stale values for three edges after reset
  always_ff @(posedge core_clk)
    up_q <= rst ? 3'h0 : (up_q == 3'h4 ? up_q : up_q + 3'h1);
  // ==========
  // properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence idle2;
    printer_strobe_n ##1 printer_strobe_n;
  endsequence
  a_strobe_width: assert property ($rose(printer_strobe_n)
    |-> lo_q == 4 * TICK_LEN) else $error("strobe width wrong");
  a_strobe_late: assert property ($changed(printer_data)
    |-> idle2) else $error("strobe not delayed");
  a_data_steady: assert property (!printer_strobe_n
    && !$past(printer_strobe_n) |-> $stable(printer_data))
    else $error("data moved under strobe");
  a_status_pad: assert property (cpu_data_oe && fetch_cycle_n
    && !read_n && addr_a0 && !addr_a1 |-> cpu_data_out[6:4] == 3'h0)
    else $error("pad bits not zero");
  a_oe_needs_io: assert property ($rose(cpu_data_oe)
    |-> !$past(io_request_n, 3) && !$past(io_request_n, 2))
    else $error("bus driven without request");
  a_oe_on_read: assert property ($rose(cpu_data_oe)
    |-> !$past(read_n, 3) || !$past(fetch_cycle_n, 3))
    else $error("bus driven in write");
  a_init_follow: assert property (up_q == 3'h4
    |-> printer_init_n == $past(board_reset_n, 3))
    else $error("init not following reset");
  a_fetch_merge: assert property (up_q == 3'h4 |-> periph_fetch_n
    == ($past(fetch_cycle_n, 3) & $past(board_reset_n, 3)))
    else $error("fetch not merged");
  a_irq_wired: assert property (irq_n_out == 1'b0)
    else $error("interrupt pin high");
  a_irq_release: assert property ($fell(irq_n_oe)
    |-> !$past(fetch_cycle_n, 4) || !$past(board_reset_n, 4))
    else $error("interrupt dropped without acknowledge");
  a_fetch_reset: assert property (fr_q > FETCH_RESET_LEN + 4
    |-> printer_strobe_n && !cpu_data_oe) else $error("no fetch reset");
endmodule

bind printer_parallel_port_glue printer_glue_chk #(
  .FETCH_RESET_LEN(FETCH_RESET_LEN), .TICK_LEN(TICK_LEN)
) printer_glue_chk_inst (
  .core_clk(core_clk), .rst(rst), .fetch_cycle_n(fetch_cycle_n),
  .io_request_n(io_request_n), .read_n(read_n), .addr_a0(addr_a0),
  .addr_a1(addr_a1), .cpu_data_out(cpu_data_out),
  .cpu_data_oe(cpu_data_oe), .board_reset_n(board_reset_n),
  .periph_fetch_n(periph_fetch_n), .printer_init_n(printer_init_n),
  .printer_data(printer_data), .printer_strobe_n(printer_strobe_n),
  .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe)
);
`default_nettype wire

// File: printer_model.sv
/*
  Behavioural printer answering each data strobe with an acknowledge.
  Assumes the bench sets ack_delay in clock cycles.
*/
`default_nettype none
module printer_model (
  input  wire logic        core_clk,
  input  wire logic        printer_strobe_n,
  input  wire logic [15:0] ack_delay,
  output logic             ack_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev;
  // ==========
  // acknowledge only after the strobe has ended
  initial begin
    ack_n = 1'b1;
    prev = 1'b1;
    forever begin
      @(negedge core_clk);
      if (prev === 1'b0 && printer_strobe_n === 1'b1) begin
        repeat (ack_delay) @(negedge core_clk);
        ack_n = 1'b0;
        repeat (3) @(negedge core_clk);
        ack_n = 1'b1;
      end
      prev = printer_strobe_n;
    end
  end
endmodule
`default_nettype wire

// File: test_printer_parallel_port_glue.sv
/*
  Self-checking bench: bus cycles, status reads, printed bytes,
  interrupt acknowledge, fetch resets. Assumes the bound checker.
*/
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module test_printer_parallel_port_glue;
  import printer_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TL = 2;
  localparam int FL = 8;
  localparam bus_pins_s IDLE = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 8'h00};
  bus_pins_s   bus;
  line_pins_s  ln;
  logic        core_clk, rst, ack_n, oe_p, st_p, stalled, cpu_data_oe;
  logic        bus_wait_n, periph_fetch_n, printer_init_n, irq_n_oe;
  logic        printer_strobe_n, irq_n_out;
  logic [7:0]  cpu_data_out, printer_data, ex;
  logic [15:0] ack_delay;
  logic [16:0] seed;
  logic [7:0]  rq[$];
  logic [7:0]  pq[$];
  int          error_cnt, compares, cyc_cnt;

  printer_parallel_port_glue #(.FETCH_RESET_LEN(FL), .TICK_LEN(TL))
    printer_parallel_port_glue_inst (
    .core_clk(core_clk), .rst(rst), .fetch_cycle_n(bus.fetch_n),
    .io_request_n(bus.ioreq_n), .read_n(bus.rd_n), .addr_a0(bus.a0),
    .chip_select_n(bus.cs_n), .addr_a1(bus.a1), .cpu_data_in(bus.data),
    .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
    .bus_wait_n(bus_wait_n), .board_reset_n(ln.board_reset_n),
    .periph_fetch_n(periph_fetch_n), .printer_init_n(printer_init_n),
    .printer_data(printer_data), .printer_strobe_n(printer_strobe_n),
    .first_channel_ack_in_n(ack_n), .printer_fault_n(ln.fault_n),
    .printer_busy(ln.busy), .printer_no_paper(ln.no_paper),
    .printer_selected(ln.selected), .serial_b_dsr_line(ln.dsr_line),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
  printer_model printer_model_inst (.core_clk(core_clk),
    .printer_strobe_n(printer_strobe_n), .ack_delay(ack_delay),
    .ack_n(ack_n));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic give_verdict();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========
  // bus cycles; the cycle is held while the block stalls the processor
  task automatic cyc(input bus_pins_s p, input int hold);
    int n;
    n = 0;
    @(negedge core_clk);
    bus = p;
    repeat (hold) @(negedge core_clk);
    while (bus_wait_n !== 1'b1 && n < 4000) begin
      stalled = 1'b1;
      n++;
      @(negedge core_clk);
    end
    bus = IDLE;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic wr(input logic a1, a0, input logic [7:0] d, input bit p);
    if (p) pq.push_back(d);
    cyc('{1'h1, 1'h0, 1'h1, 1'h0, a1, a0, d}, 5);
  endtask
  task automatic rd(input logic a1, a0, input logic [7:0] e);
    rq.push_back(e);
    cyc('{1'h1, 1'h0, 1'h0, 1'h0, a1, a0, 8'h00}, 5);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (pq.size() > 0 && n < 5000) begin
      n++;
      @(negedge core_clk);
    end
    repeat (30) @(negedge core_clk);
  endtask

  // ==========
  // result watcher: oldest note against each result
  always @(negedge core_clk) begin
    cyc_cnt++;
    if (cpu_data_oe === 1'h1 && oe_p !== 1'h1) begin
      ex = rq.size() > 0 ? rq.pop_front() : 8'hXX;
      `CHK(cpu_data_out, ex)
    end
    if (printer_strobe_n === 1'h0 && st_p === 1'h1) begin
      ex = pq.size() > 0 ? pq.pop_front() : 8'hXX;
      `CHK(printer_data, ex)
    end
    oe_p = cpu_data_oe;
    st_p = printer_strobe_n;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    bus = IDLE;
    ln = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
    rst = 1'h1;
    ack_delay = 16'h0002;
    seed = 17'h17B0C;
    stalled = 1'h0;
    repeat (12) @(negedge core_clk);
    `CHK(printer_strobe_n, 1'h1)
    `CHK(printer_init_n, 1'h0)
    rst = 1'h0;
    repeat (8) @(negedge core_clk);
    wr(1'h1, 1'h0, 8'h40, 0);
    wr(1'h1, 1'h0, 8'h87, 0);
    wr(1'h1, 1'h0, 8'h0F, 0);
    wr(1'h1, 1'h1, 8'hCF, 0);
    wr(1'h1, 1'h1, 8'hFF, 0);
    rd(1'h1, 1'h0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      ln[4:0] = seed[4:0];
      rd(1'h0, 1'h1, {~seed[4], 3'h0, seed[3:0]});
    end
    seed = lfsr(seed);
    wr(1'h0, 1'h0, seed[7:0], 1);
    drain();
    `CHK(irq_n_oe, 1'h1)
    rq.push_back(8'h40);
    cyc('{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 8'h00}, 5);
    // channel B interrupt on bit 7 alone, then switched off again
    ln.dsr_line = 1'h1;
    wr(1'h1, 1'h1, 8'h20, 0);
    wr(1'h1, 1'h1, 8'h97, 0);
    wr(1'h1, 1'h1, 8'h7F, 0);
    for (int i = 0; i < 2; i++) begin
      ln.dsr_line = 1'h0;
      repeat (8) @(negedge core_clk);
      `CHK(irq_n_oe, i == 0)
      if (i == 0) begin
        rq.push_back(8'h20);
        cyc('{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 8'h00}, 5);
        ln.dsr_line = 1'h1;
        wr(1'h1, 1'h1, 8'h03, 0);
      end
    end
    // slow printer backs writes up until the processor stalls
    ack_delay = 16'h0028;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr(1'h0, 1'h0, seed[7:0], 1);
    end
    drain();
    `CHK(stalled, 1'h1)
    ack_delay = 16'h0002;
    cyc('{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 8'hA5}, 5);
    wr(1'h0, 1'h1, 8'h5A, 0);
    cyc('{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 8'h00}, 3);
    wr(1'h0, 1'h0, 8'hC3, 1);
    cyc('{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 8'h00}, 16);
    wr(1'h0, 1'h0, 8'h3C, 0);
    wr(1'h1, 1'h0, 8'h0F, 0);
    wr(1'h0, 1'h0, 8'h96, 1);
    drain();
    ln.board_reset_n = 1'h0;
    repeat (5) @(negedge core_clk);
    `CHK(printer_init_n, 1'h0)
    `CHK(periph_fetch_n, 1'h0)
    ln.board_reset_n = 1'h1;
    repeat (6) @(negedge core_clk);
    `CHK(printer_init_n, 1'h1)
    `CHK(32'(pq.size()), 32'h0)
    give_verdict();
  end
endmodule
`default_nettype wire
